/* design/wim_pkg.sv */
package wim_pkg;

  // ****************************************************************
  // sizes and clock
  // ****************************************************************
  localparam int NUM_WAKE = 3;
  localparam int NUM_ALT = 2;
  localparam int NUM_CHAN = NUM_WAKE + NUM_ALT;
  localparam int CLK_KHZ = 50000;
  localparam int CNT_W = 12;

  // ****************************************************************
  // filter times
  // ****************************************************************
  localparam int FILT_SHORT_US = 16;
  localparam int FILT_LONG_US = 64;
  localparam logic [CNT_W-1:0] FILT_SHORT_CYC =
    CNT_W'((FILT_SHORT_US * CLK_KHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] FILT_LONG_CYC =
    CNT_W'((FILT_LONG_US * CLK_KHZ + 999) / 1000);

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int ADR_W = 5;
  localparam logic [ADR_W-1:0] OFS_PULL = 5'h00;
  localparam logic [ADR_W-1:0] OFS_FILT = 5'h04;
  localparam logic [ADR_W-1:0] OFS_WAKE_EN = 5'h08;
  localparam logic [ADR_W-1:0] OFS_SRC = 5'h0C;
  localparam logic [ADR_W-1:0] OFS_ALT_SRC = 5'h10;
  localparam logic [ADR_W-1:0] OFS_LEVEL = 5'h14;
  localparam logic [ADR_W-1:0] OFS_MASK = 5'h18;

  localparam logic [5:0] PULL_RST = 6'h00;
  localparam logic [5:0] FILT_RST = 6'h00;
  localparam logic [4:0] WAKE_EN_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;

  // ****************************************************************
  // field encodings
  // ****************************************************************
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam logic [1:0] FILT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FILT_STATIC_LONG = 2'h1;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_FAILSAFE
  } wimMode_e;

  typedef struct packed {
    logic [1:0] pull;
    logic [1:0] filt;
  } wimChanCfg_s;

endpackage

/* design/wim_top.sv */
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps

module wim_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [wim_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [wim_pkg::NUM_WAKE-1:0] wakePin,
  input wire logic [wim_pkg::NUM_ALT-1:0] failPin,
  input wire logic [1:0] timerWindow,
  input wire wim_pkg::wimMode_e sbcMode,
  output logic [wim_pkg::NUM_WAKE-1:0] pullUpEn,
  output logic [wim_pkg::NUM_WAKE-1:0] pullDownEn,
  output logic wakeReq,
  output logic irq
);

  localparam int NW = wim_pkg::NUM_WAKE;
  localparam int NC = wim_pkg::NUM_CHAN;
  localparam int CW = wim_pkg::CNT_W;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [5:0] pullCfg;
  logic [5:0] filtCfg;
  logic [4:0] wakeEn;
  logic [NW-1:0] srcStat;
  logic [wim_pkg::NUM_ALT-1:0] altStat;
  logic [NW-1:0] levelStat;
  logic [4:0] irqMask;

  logic [NC-1:0] syncA;
  logic [NC-1:0] syncB;
  logic [NC-1:0] stable;
  logic [CW-1:0] cnt [NC];
  logic [1:0] winPrev;

  logic [NC-1:0] chanActive;
  logic [NC-1:0] accept;
  logic [CW-1:0] next_cnt [NC];
  logic [31:0] rdData;
  logic busReq;
  logic busWr;
  logic lowMode;

  function automatic wim_pkg::wimChanCfg_s chanCfg(input int c);
    wim_pkg::wimChanCfg_s cfg;
    cfg.pull = pullCfg[2*c +: 2];
    cfg.filt = filtCfg[2*c +: 2];
    return cfg;
  endfunction

  function automatic logic [CW-1:0] filtLimit(input logic [1:0] filt);
    logic [CW-1:0] lim;
    lim = wim_pkg::FILT_SHORT_CYC;
    if (filt == wim_pkg::FILT_STATIC_LONG) begin
      lim = wim_pkg::FILT_LONG_CYC;
    end
    return lim;
  endfunction

  // a write lands at the edge where the master sees ack, never earlier,
  // so a request dropped before its ack leaves no trace
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                 wb_sel_i[0];
  assign lowMode = (sbcMode == wim_pkg::MODE_SLEEP) ||
                   (sbcMode == wim_pkg::MODE_FAILSAFE);

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  // syncA feeds syncB only; everything downstream looks at syncB
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      syncA <= '0;
      syncB <= '0;
    end else if (clkEn) begin
      syncA <= {failPin, wakePin};
      syncB <= syncA;
    end
  end

  // ****************************************************************
  // deglitch filter
  // ****************************************************************
  always_comb begin
    wim_pkg::wimChanCfg_s cfg;
    logic [CW-1:0] lim;
    cfg = '0;
    lim = '0;
    for (int c = 0; c < NC; c++) begin
      if (c < NW) begin
        cfg = chanCfg(c);
        lim = filtLimit(cfg.filt);
        // cyclic sense watches the pin only inside the timer window
        chanActive[c] = cfg.filt[1] ? timerWindow[cfg.filt[0]] : 1'b1;
      end else begin
        lim = wim_pkg::FILT_SHORT_CYC;
        chanActive[c] = wakeEn[c];
      end
      accept[c] = 1'b0;
      next_cnt[c] = '0;
      if (chanActive[c] && (syncB[c] != stable[c])) begin
        if (cnt[c] == lim - 1'b1) begin
          accept[c] = 1'b1;
        end else begin
          // stops at lim - 1, so CNT_W bits hold even the long filter
          next_cnt[c] = CW'(cnt[c] + 1'b1);
        end
      end
    end
  end

  // a bounce back clears the count, so the event is dropped
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stable <= '0;
      for (int c = 0; c < NC; c++) begin
        cnt[c] <= '0;
      end
    end else if (clkEn) begin
      for (int c = 0; c < NC; c++) begin
        cnt[c] <= next_cnt[c];
        if (accept[c]) begin
          stable[c] <= syncB[c];
        end else if (c >= NW && !chanActive[c]) begin
          // track quietly so enabling the alternate input is no event
          stable[c] <= syncB[c];
        end
      end
    end
  end

  // ****************************************************************
  // level status
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      winPrev <= '0;
      levelStat <= '0;
    end else if (clkEn) begin
      winPrev <= timerWindow;
      for (int c = 0; c < NW; c++) begin
        // low-power modes keep the last reading taken while awake
        if (!lowMode) begin
          if (!filtCfg[2*c+1]) begin
            levelStat[c] <= syncB[c];
          end else if (winPrev[filtCfg[2*c]] &&
                       !timerWindow[filtCfg[2*c]]) begin
            levelStat[c] <= syncB[c];
          end
        end
      end
    end
  end

  // ****************************************************************
  // pull current sources
  // ****************************************************************
  // automatic mode follows the filtered level so noise cannot toggle it
  // the sources settle one cycle after the filtered level moves
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pullUpEn <= '0;
      pullDownEn <= '0;
    end else if (clkEn) begin
      for (int c = 0; c < NW; c++) begin
        case (pullCfg[2*c +: 2])
          wim_pkg::PULL_NONE: begin
            pullUpEn[c] <= 1'b0;
            pullDownEn[c] <= 1'b0;
          end
          wim_pkg::PULL_DOWN: begin
            pullUpEn[c] <= 1'b0;
            pullDownEn[c] <= 1'b1;
          end
          wim_pkg::PULL_UP: begin
            pullUpEn[c] <= 1'b1;
            pullDownEn[c] <= 1'b0;
          end
          default: begin
            pullUpEn[c] <= stable[c];
            pullDownEn[c] <= !stable[c];
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // wake source status and interrupt
  // ****************************************************************
  // set wins over a write-one-to-clear in the same cycle
  // a disabled wake input still filters; it only leaves no source bit and raises no wake request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      srcStat <= '0;
      altStat <= '0;
    end else if (clkEn) begin
      for (int c = 0; c < NW; c++) begin
        if (accept[c] && wakeEn[c]) begin
          srcStat[c] <= 1'b1;
        end else if (busWr && wb_adr_i == wim_pkg::OFS_SRC &&
                     wb_dat_i[c]) begin
          srcStat[c] <= 1'b0;
        end
      end
      for (int a = 0; a < wim_pkg::NUM_ALT; a++) begin
        if (accept[NW+a]) begin
          altStat[a] <= 1'b1;
        end else if (busWr && wb_adr_i == wim_pkg::OFS_ALT_SRC &&
                     wb_dat_i[a]) begin
          altStat[a] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq <= 1'b0;
      wakeReq <= 1'b0;
    end else if (clkEn) begin
      // low-power modes wake instead of interrupting
      // status still latches while asleep, so software sees the source
      irq <= !lowMode && |({altStat, srcStat} & irqMask);
      wakeReq <= lowMode &&
                 |(accept & {wakeEn[4:3], wakeEn[NW-1:0]});
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  // all fields sit in the low byte; upper bits read as zero
  always_comb begin
    rdData = '0;
    case (wb_adr_i)
      wim_pkg::OFS_PULL: rdData[5:0] = pullCfg;
      wim_pkg::OFS_FILT: rdData[5:0] = filtCfg;
      wim_pkg::OFS_WAKE_EN: rdData[4:0] = wakeEn;
      wim_pkg::OFS_SRC: rdData[NW-1:0] = srcStat;
      wim_pkg::OFS_ALT_SRC: rdData[wim_pkg::NUM_ALT-1:0] = altStat;
      wim_pkg::OFS_LEVEL: rdData[NW-1:0] = levelStat;
      wim_pkg::OFS_MASK: rdData[4:0] = irqMask;
      default: rdData = '0;
    endcase
  end

  // every access, mapped or not, is acked one cycle after the request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clkEn) begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pullCfg <= wim_pkg::PULL_RST;
      filtCfg <= wim_pkg::FILT_RST;
      wakeEn <= wim_pkg::WAKE_EN_RST;
      irqMask <= wim_pkg::MASK_RST;
    end else if (clkEn && busWr) begin
      // status and level registers have no entry: read-only or W1C
      case (wb_adr_i)
        wim_pkg::OFS_PULL: pullCfg <= wb_dat_i[5:0];
        wim_pkg::OFS_FILT: filtCfg <= wb_dat_i[5:0];
        wim_pkg::OFS_WAKE_EN: wakeEn <= wb_dat_i[4:0];
        wim_pkg::OFS_MASK: irqMask <= wb_dat_i[4:0];
        default: ;
      endcase
    end
  end

endmodule // wim_top

/* dv/wim_checker.sv */
`timescale 1ns/100ps
// ****
// bus and wake checks
// ****
module wim_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [wim_pkg::NUM_WAKE-1:0] wakePin,
  input wire logic [wim_pkg::NUM_ALT-1:0] failPin,
  input wire wim_pkg::wimMode_e sbcMode,
  input wire logic [wim_pkg::NUM_WAKE-1:0] pullUpEn,
  input wire logic [wim_pkg::NUM_WAKE-1:0] pullDownEn,
  input wire logic wakeReq,
  input wire logic irq
);
  logic [11:0] quiet;
  logic [4:0] pinsQ;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // cycles since any pin moved; saturates so long idle spans stay legal
  always_ff @(posedge mclk) begin
    pinsQ <= {failPin, wakePin};
    if (!nrst || pinsQ != {failPin, wakePin})
      quiet <= 12'h000;
    else if (quiet != 12'hFFF)
      quiet <= quiet + 12'h001;
  end
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn
    |=> wb_ack_o) else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
    else $error("ack too long");
  AST_PULL_EXCL: assert property ((pullUpEn & pullDownEn) == 3'h0)
    else $error("both pulls on");
  AST_WAKE_PULSE: assert property (wakeReq && clkEn |=> !wakeReq)
    else $error("wake request too long");
  AST_WAKE_MODE: assert property (wakeReq |->
    $past(sbcMode) >= wim_pkg::MODE_SLEEP) else $error("wake when awake");
  AST_IRQ_MODE: assert property (irq |->
    $past(sbcMode) < wim_pkg::MODE_SLEEP) else $error("irq while asleep");
  AST_FILTER: assert property (wakeReq |-> quiet >= 12'h320)
    else $error("wake before filter time");
  // a write lands at the ack edge; irq falls one edge later, and $fell sees it the edge after
  AST_IRQ_HOLD: assert property ($fell(irq) |->
    ($past(wb_ack_o, 2) && $past(wb_we_i, 2)) ||
    $past(sbcMode) >= wim_pkg::MODE_SLEEP)
    else $error("status lost without clear");
endmodule // wim_checker
bind wim_top wim_checker wim_checker_i (.mclk, .nrst, .clkEn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_ack_o, .wakePin, .failPin, .sbcMode, .pullUpEn,
  .pullDownEn, .wakeReq, .irq);

/* dv/wim_switches.sv */
`timescale 1ns/100ps
// ****
// switch contacts on the wake pins
// ****
module wim_switches (
  input wire logic mclk,
  input wire logic [2:0] closed,
  input wire logic [2:0] level,
  input wire logic [2:0] pullUpEn,
  input wire logic [2:0] pullDownEn,
  output logic [2:0] wakePin
);
  initial wakePin = 3'h0;
  // an open unpulled contact floats; toggling stops a steady guess
  always @(posedge mclk)
    for (int i = 0; i < 3; i++)
      wakePin[i] <= closed[i] ? level[i] : pullUpEn[i] ? 1'h1 :
        pullDownEn[i] ? 1'h0 : ~wakePin[i];
endmodule // wim_switches

/* dv/wim_top_tb.sv */
`timescale 1ns/100ps
module wim_top_tb;
  logic mclk = 1'h0, nrst = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, rv, datO;
  logic [2:0] pinLvl = 3'h0, pinClosed = 3'h7, wakePin, pullUpEn, pullDownEn;
  logic [1:0] failPin = 2'h0, timerWindow = 2'h0;
  wim_pkg::wimMode_e sbcMode = wim_pkg::MODE_NORMAL;
  logic ack, wakeReq, irq;
  logic [31:0] expQ[$];
  int errors = 0, compares = 0, wakes = 0;
  always #10 mclk = ~mclk;
  wim_top wim_top_i (.mclk, .nrst, .clkEn(1'h1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .wakePin, .failPin,
    .timerWindow, .sbcMode, .pullUpEn, .pullDownEn, .wakeReq, .irq);
  wim_switches wim_switches_i (.mclk, .closed(pinClosed), .level(pinLvl),
    .pullUpEn, .pullDownEn, .wakePin);
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    // no cycle count assumed; only the watchdog ends a wait
    do begin
      @(posedge mclk);
    end while (ack !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic give_verdict();
    // a note never matched by a read answer is a missed comparison
    if (expQ.size() != 0) errors++;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // read data is checked at the ack edge, oldest note first
  always @(posedge mclk)
    if (ack === 1'h1 && !we && expQ.size() > 0)
      chk(datO, expQ.pop_front());
  always @(posedge mclk)
    if (wakeReq === 1'h1) wakes++;
  initial begin
    wt(40000);
    errors++;
    give_verdict();
  end
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(55430));
    wt(20);
    nrst <= 1'h1;
    for (int a = 0; a < 8; a++)
      rd(5'(a * 4), 32'h0);
    rv = $urandom;
    bus(1'h1, wim_pkg::OFS_MASK, rv);
    rd(wim_pkg::OFS_MASK, rv & 32'h1F);
    bus(1'h1, wim_pkg::OFS_MASK, 32'h1F);
    for (int c = 0; c < 4; c++) begin
      bus(1'h1, wim_pkg::OFS_PULL, 32'(c));
      wt(2);
      chk(32'({pullUpEn[0], pullDownEn[0]}), c == 3 ? 32'h1 : 32'(c));
    end
    bus(1'h1, wim_pkg::OFS_WAKE_EN, 32'h1D);
    pinLvl[0] <= 1'h1;
    wt(1 + $urandom % 700);
    pinLvl[0] <= 1'h0;
    wt(900);
    rd(wim_pkg::OFS_SRC, 32'h0);
    pinLvl[0] <= 1'h1;
    wt(810);
    rd(wim_pkg::OFS_SRC, 32'h1);
    rd(wim_pkg::OFS_LEVEL, 32'h1);
    chk(32'(irq), 32'h1);
    chk(32'(pullUpEn[0]), 32'h1);
    bus(1'h1, wim_pkg::OFS_SRC, 32'h1);
    wt(3);
    chk(32'(irq), 32'h0);
    pinLvl[0] <= 1'h0;
    pinLvl[1] <= 1'h1;
    wt(810);
    rd(wim_pkg::OFS_SRC, 32'h1);
    rd(wim_pkg::OFS_LEVEL, 32'h2);
    bus(1'h1, wim_pkg::OFS_SRC, 32'h1);
    bus(1'h1, wim_pkg::OFS_FILT, 32'h10);
    pinLvl[2] <= 1'h1;
    wt(2000);
    rd(wim_pkg::OFS_SRC, 32'h0);
    wt(1300);
    rd(wim_pkg::OFS_SRC, 32'h4);
    bus(1'h1, wim_pkg::OFS_SRC, 32'h4);
    sbcMode <= wim_pkg::MODE_SLEEP;
    pinLvl[2] <= 1'h0;
    pinLvl[1] <= 1'h0;
    wt(3300);
    chk(wakes, 32'h1);
    chk(32'(irq), 32'h0);
    sbcMode <= wim_pkg::MODE_NORMAL;
    bus(1'h1, wim_pkg::OFS_SRC, 32'h4);
    bus(1'h1, wim_pkg::OFS_FILT, 32'h12);
    pinLvl[0] <= 1'h1;
    wt(900);
    rd(wim_pkg::OFS_LEVEL, 32'h0);
    rd(wim_pkg::OFS_SRC, 32'h0);
    timerWindow[0] <= 1'h1;
    wt(900);
    timerWindow[0] <= 1'h0;
    wt(3);
    rd(wim_pkg::OFS_LEVEL, 32'h1);
    rd(wim_pkg::OFS_SRC, 32'h1);
    failPin[0] <= 1'h1;
    wt(810);
    rd(wim_pkg::OFS_ALT_SRC, 32'h1);
    wt(2);
    give_verdict();
  end
endmodule // wim_top_tb
